// ---- dhp_pkg.sv ----
`default_nettype none
package dhp_pkg;
    localparam int DHP_CHANNELS = 2;
    localparam int DHP_DATA_W = 8;
    localparam int DHP_ADDR_W = 3;
    localparam int DHP_NREGS = 8;
    localparam int DHP_NCAUSE = 4;
    localparam int DHP_SYNC_STAGES = 2;
    localparam logic [2:0] DHP_IER_OFS = 3'h1;
    localparam logic [2:0] DHP_ISR_OFS = 3'h2;
    localparam logic [2:0] DHP_MCR_OFS = 3'h4;
    localparam int DHP_MCR_GATE_BIT = 3;
    localparam int DHP_CAUSE_RX_ERR = 0;
    localparam int DHP_CAUSE_RX_DATA = 1;
    localparam int DHP_CAUSE_TX_EMPTY = 2;
    localparam int DHP_CAUSE_MODEM = 3;
    localparam logic [7:0] DHP_REG_RST = 8'h00;

    typedef struct packed {
        logic [1:0] sel_n;
        logic rd_n;
        logic wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } dhp_pins_t;

    localparam dhp_pins_t DHP_PINS_IDLE = '{sel_n: 2'h3, rd_n: 1'b1, wr_n: 1'b1,
        addr: 3'h0, data: 8'h00};

    typedef struct packed {
        logic [1:0] rd_pulse;
        logic [1:0] wr_pulse;
        logic [2:0] addr;
        logic [7:0] wdata;
    } dhp_core_req_t;
endpackage

`timescale 1ns/1ns
module dhp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Asynchronous in, synchronised out.
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Only the second stage is read outside this module.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

// ---- dhp_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module dhp_port (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Host pins.
    input wire logic channel_a_select_n,
    input wire logic channel_b_select_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [dhp_pkg::DHP_ADDR_W-1:0] reg_select,
    input wire logic [dhp_pkg::DHP_DATA_W-1:0] bus_in,
    output logic [dhp_pkg::DHP_DATA_W-1:0] bus_out,
    output logic bus_oe,
    // Interrupt and user outputs.
    output logic channel_a_irq,
    output logic channel_a_irq_oe,
    output logic channel_b_irq,
    output logic channel_b_irq_oe,
    output logic channel_a_user_out,
    output logic channel_b_user_out,
    // UART core side.
    input wire logic [dhp_pkg::DHP_NCAUSE-1:0] irq_cause_a,
    input wire logic [dhp_pkg::DHP_NCAUSE-1:0] irq_cause_b,
    output dhp_pkg::dhp_core_req_t core_req
);
    import dhp_pkg::*;

    dhp_pins_t pins_raw;
    dhp_pins_t pins_s;
    logic rd_n_q;
    logic wr_n_q;
    logic rd_fall;
    logic wr_fall;
    logic [DHP_CHANNELS-1:0] sel;
    logic [DHP_CHANNELS-1:0][DHP_NCAUSE-1:0] cause;
    logic [DHP_CHANNELS-1:0][DHP_DATA_W-1:0] ch_rdata;
    logic [DHP_CHANNELS-1:0] irq_q;
    logic [DHP_CHANNELS-1:0] irq_oe_q;
    logic [DHP_CHANNELS-1:0] user_q;
    logic [DHP_DATA_W-1:0] rdata_q;
    logic bus_oe_q;
    dhp_core_req_t core_req_q;

    // Address bit zero of the pins is the least significant register index bit.
    assign pins_raw = '{sel_n: {channel_b_select_n, channel_a_select_n},
        rd_n: host_read_strobe_n, wr_n: host_write_strobe_n,
        addr: reg_select, data: bus_in};

    // Every host pin is asynchronous to clk_sys and is synchronised first.
    dhp_sync #(
        .WIDTH($bits(dhp_pins_t)),
        .RST_VAL(DHP_PINS_IDLE)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign cause[0] = irq_cause_a;
    assign cause[1] = irq_cause_b;
    assign sel = ~pins_s.sel_n;
    assign rd_fall = rd_n_q & ~pins_s.rd_n;
    assign wr_fall = wr_n_q & ~pins_s.wr_n;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            rd_n_q <= pins_s.rd_n;
            wr_n_q <= pins_s.wr_n;
        end
    end

    for (genvar ch = 0; ch < DHP_CHANNELS; ch++) begin : g_chan
        logic [DHP_DATA_W-1:0] regs_q [DHP_NREGS];
        logic [DHP_NCAUSE-1:0] pending;
        logic gate;

        // Bus bit zero lands in register bit zero, which the core
        // sends and receives first on the serial line.
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                for (int i = 0; i < DHP_NREGS; i++) begin
                    regs_q[i] <= DHP_REG_RST;
                end
            end else if (wr_fall && sel[ch]) begin
                regs_q[pins_s.addr] <= pins_s.data;
            end
        end

        // Enabled sources over all four causes.
        assign pending = cause[ch] & regs_q[DHP_IER_OFS][DHP_NCAUSE-1:0];
        assign gate = regs_q[DHP_MCR_OFS][DHP_MCR_GATE_BIT];

        // The status offset reports the enabled, pending causes.
        assign ch_rdata[ch] = (pins_s.addr == DHP_ISR_OFS) ?
            {{(DHP_DATA_W-DHP_NCAUSE){1'b0}}, pending} : regs_q[pins_s.addr];

        // One gate bit steers both outputs; the system should use only one.
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                irq_q[ch] <= 1'b0;
                irq_oe_q[ch] <= 1'b0;
                user_q[ch] <= 1'b1;
            end else begin
                irq_q[ch] <= gate & (|pending);
                irq_oe_q[ch] <= gate;
                user_q[ch] <= ~gate;
            end
        end
    end

    // Channel A wins the bus if a host wrongly selects both for a read.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= '0;
            bus_oe_q <= 1'b0;
        end else begin
            bus_oe_q <= ~pins_s.rd_n & (|sel);
            if (~pins_s.rd_n && sel[0]) begin
                rdata_q <= ch_rdata[0];
            end else if (~pins_s.rd_n && sel[1]) begin
                rdata_q <= ch_rdata[1];
            end
        end
    end

    // Access pulses tell the core about reads and writes with side effects.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            core_req_q <= '0;
        end else begin
            core_req_q.rd_pulse <= {2{rd_fall}} & sel;
            core_req_q.wr_pulse <= {2{wr_fall}} & sel;
            core_req_q.addr <= pins_s.addr;
            core_req_q.wdata <= pins_s.data;
        end
    end

    assign bus_out = rdata_q;
    assign bus_oe = bus_oe_q;
    assign channel_a_irq = irq_q[0];
    assign channel_b_irq = irq_q[1];
    assign channel_a_irq_oe = irq_oe_q[0];
    assign channel_b_irq_oe = irq_oe_q[1];
    assign channel_a_user_out = user_q[0];
    assign channel_b_user_out = user_q[1];
    assign core_req = core_req_q;
endmodule
`default_nettype wire

// ---- dhp_port_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module dhp_port_chk (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Host pins.
    input wire logic channel_a_select_n,
    input wire logic channel_b_select_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [7:0] bus_in,
    // Outputs, and the channel A cause input.
    input wire logic bus_oe,
    input wire logic channel_a_irq,
    input wire logic channel_a_irq_oe,
    input wire logic channel_b_irq_oe,
    input wire logic channel_a_user_out,
    input wire logic channel_b_user_out,
    input wire logic [3:0] irq_cause_a,
    input wire dhp_pkg::dhp_core_req_t core_req
);
    import dhp_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_gate_a: assert property (channel_a_irq_oe ^ channel_a_user_out)
        else $error("gate A");
    a_gate_b: assert property (channel_b_irq_oe ^ channel_b_user_out)
        else $error("gate B");
    a_irq_src: assert property (channel_a_irq |-> $past(|irq_cause_a) && channel_a_irq_oe)
        else $error("irq A");
    a_wr_src: assert property (core_req.wr_pulse[0] |->
        $past(!channel_a_select_n && !host_write_strobe_n, 3)) else $error("write A");
    a_wr_data: assert property (core_req.wr_pulse[0] |-> core_req.wdata == $past(bus_in, 3))
        else $error("wdata");
    a_rd_src: assert property (core_req.rd_pulse[1] |->
        $past(!channel_b_select_n && !host_read_strobe_n, 3)) else $error("read B");
    a_bus_rise: assert property ($rose(bus_oe) |-> $past(!host_read_strobe_n, 3))
        else $error("bus on");
    a_bus_fall: assert property ($fell(bus_oe) |-> $past(host_read_strobe_n, 3))
        else $error("bus off");
    c_write: cover property (core_req.wr_pulse[0]);
    c_read: cover property ($rose(bus_oe));
    c_irq: cover property (channel_a_irq);
endmodule
bind dhp_port dhp_port_chk dhp_port_chk_inst (.*);
`default_nettype wire

// ---- dhp_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dhp_bus_model (
    // Bus drivers.
    input wire logic clk_sys,
    input wire logic bus_oe,
    input wire logic [7:0] bus_out,
    input wire logic h_oe,
    input wire logic [7:0] host_d,
    // Resolved wire.
    output logic [7:0] bus_in
);
    logic [7:0] last_q = 8'h00;
    // An undriven bus toggles so that stale data never looks valid.
    always_comb bus_in = (bus_oe === 1'b1) ? bus_out : h_oe ? host_d : ~last_q;
    always_ff @(posedge clk_sys) last_q <= bus_in;
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dhp_pkg::*;
    logic clk_sys = 0, srst = 1, h_oe = 0;
    logic channel_a_select_n = 1, channel_b_select_n = 1;
    logic host_read_strobe_n = 1, host_write_strobe_n = 1;
    logic [2:0] reg_select = 3'h0;
    logic [7:0] host_d = 8'h00, d, bus_in, bus_out;
    logic [3:0] irq_cause_a = 4'h0, irq_cause_b = 4'hF;
    logic bus_oe, channel_a_irq, channel_a_irq_oe, channel_b_irq, channel_b_irq_oe;
    logic channel_a_user_out, channel_b_user_out;
    dhp_core_req_t core_req;
    int num_errors = 0, cmp_count = 0;
    localparam logic [11:0] ROWS [4] = '{12'h0A5, 12'hD5A, 12'h701, 12'hB80};
    always #10 clk_sys = ~clk_sys;
    dhp_port dhp_port_inst (.*);
    dhp_bus_model dhp_bus_model_inst (.*);
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic acc(input logic b, input logic w, input logic [2:0] a, inout logic [7:0] v);
        @(posedge clk_sys) #2;
        {channel_b_select_n, channel_a_select_n} = b ? 2'b01 : 2'b10;
        reg_select = a;
        host_d = v;
        h_oe = w;
        {host_read_strobe_n, host_write_strobe_n} = w ? 2'b10 : 2'b01;
        repeat (5) @(posedge clk_sys);
        #2 v = bus_in;
        {host_read_strobe_n, host_write_strobe_n} = 2'b11;
        repeat (5) @(posedge clk_sys);
        #2 {channel_b_select_n, channel_a_select_n, h_oe} = 3'b110;
    endtask
    task automatic wra(input logic [2:0] a, input logic [7:0] v);
        d = v;
        acc(0, 1, a, d);
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #2 srst = 0;
        chk(!bus_oe && channel_a_user_out && !channel_a_irq_oe, "reset");
        foreach (ROWS[i]) wra(ROWS[i][10:8], ROWS[i][7:0]);
        foreach (ROWS[i]) begin
            if (ROWS[i][11]) begin
                d = ROWS[i][7:0];
                acc(1, 1, ROWS[i][10:8], d);
            end
        end
        foreach (ROWS[i]) begin
            acc(ROWS[i][11], 0, ROWS[i][10:8], d);
            chk(d === ROWS[i][7:0], "read back");
        end
        acc(1, 0, 3'h0, d);
        chk(d === 8'h00, "channel B kept apart");
        chk(!bus_oe, "bus released");
        wra(DHP_IER_OFS, 8'h0F);
        chk(core_req.addr === DHP_IER_OFS && core_req.wr_pulse === 2'b00, "core req");
        wra(DHP_MCR_OFS, 8'h08);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys) #2 irq_cause_a = 4'(1 << i);
            repeat (2) @(posedge clk_sys);
            #2 chk(channel_a_irq && !channel_a_user_out, "irq on");
        end
        chk(channel_b_irq === 1'b0, "irq B");
        chk(channel_b_user_out && !channel_b_irq_oe, "user B");
        wra(DHP_MCR_OFS, 8'h00);
        chk(!channel_a_irq && !channel_a_irq_oe && channel_a_user_out, "gate off");
        wra(DHP_MCR_OFS, 8'h08);
        wra(DHP_IER_OFS, 8'h00);
        chk(!channel_a_irq && channel_a_irq_oe, "masked");
        conclude();
    end
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
